// ==== bench/flic_cpu_model.sv ====
// cpu sequencer model: instruction end status and return-from-interrupt
`default_nettype none
module flic_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controller timing
  input wire logic cycle_end,
  // test control
  input wire logic ret_req,
  input wire logic long_instr,
  // to controller
  output var flic_pkg::flic_cpu_type cpu
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_ff;
  logic pend_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 2'h0;
      pend_ff <= 1'b0;
      cpu <= '0;
    end else begin
      cpu.interrupt_return <= 1'b0;
      if (cycle_end) begin
        cnt_ff <= cpu.final_cycle ? 2'h0 : cnt_ff + 2'h1;
        // four-cycle instructions while long_instr is set
        cpu.final_cycle <= !long_instr || (!cpu.final_cycle && cnt_ff == 2'h2);
        if (pend_ff && cpu.final_cycle) begin
          cpu.interrupt_return <= 1'b1;
          pend_ff <= 1'b0;
        end
      end
      if (ret_req) begin
        pend_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_four_level_interrupt_controller.sv ====
// self-checking bench of the four-level interrupt controller
`default_nettype none
module test_four_level_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic reset_n;
  flic_pkg::flic_sfr_req_type req;
  logic [7:0] rdata;
  logic hit;
  logic [1:0] pin_n;
  logic [1:0] latch;
  flic_pkg::flic_periph_type per;
  flic_pkg::flic_cpu_type cpu;
  flic_pkg::flic_vec_type vec;
  logic cend;
  logic [3:0] lact;
  logic spt;
  logic rq;
  logic lng;
  logic [1:0] lv;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [12:0] pm [13] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0008,
    13'h0010, 13'h0020, 13'h0040, 13'h0080, 13'h0004, 13'h0002, 13'h0001};
  logic [15:0] va [13] = '{16'h000b, 16'h001b, 16'h002b, 16'h002b, 16'h0043, 16'h004b,
    16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h009b, 16'h0023, 16'h0083};
  logic [7:0] fb [13] = '{8'h00, 8'h00, 8'h40, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ra [8] = '{8'ha8, 8'hb8, 8'h9a, 8'ha9, 8'hb9, 8'h88, 8'hc0, 8'he1};

  flic_controller flic_controller_i (
    .MCLK(mclk), .RESET_N(reset_n), .SFR_REQ(req), .SFR_RDATA(rdata), .SFR_HIT(hit),
    .EXT01_PIN_N(pin_n), .EXT01_LATCH(latch), .PERIPH(per), .CPU(cpu), .VEC(vec),
    .SAMPLE_POINT(spt), .CYCLE_END(cend), .LEVEL_ACTIVE(lact));
  flic_cpu_model flic_cpu_model_i (
    .clk(mclk), .reset_n(reset_n), .cycle_end(cend), .ret_req(rq), .long_instr(lng),
    .cpu(cpu));

  always #4 mclk = ~mclk;

  // ****
  // tasks
  // ****
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) req = '{a, d, 1'b1};
    @(negedge mclk) req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk) req.addr = a;
    @(negedge mclk);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // waits for the hardware call and checks what it carries
  task automatic vw(input logic [15:0] a, input logic [1:0] l);
    int k;
    k = 0;
    while (vec.call !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    chk("call", 16'h1, {15'h0, vec.call});
    chk("vector", a, vec.addr);
    chk("level", {14'h0, l}, {14'h0, vec.level});
    chk("level_active", 16'h1, {15'h0, lact[l]});
    @(negedge mclk);
  endtask

  task automatic nv(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if (vec.call === 1'b1) c++;
    end
    chk("no_call", 16'h0, c[15:0]);
  endtask

  task automatic ret(input logic [3:0] e);
    int k;
    @(negedge mclk) rq = 1'b1;
    @(negedge mclk) rq = 1'b0;
    k = 0;
    while (lact !== e && k < 120) begin
      @(negedge mclk);
      k++;
    end
    chk("level_active", {12'h0, e}, {12'h0, lact});
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    req = '0;
    pin_n = 2'h3;
    latch = 2'h3;
    per = '0;
    rq = 1'b0;
    lng = 1'b0;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    // sample point two clocks before the end of each machine cycle
    while (cend !== 1'b1) @(negedge mclk);
    repeat (10) @(negedge mclk);
    chk("sample_point", 16'h1, {15'h0, spt});
    repeat (2) @(negedge mclk);
    chk("cycle_end", 16'h1, {15'h0, cend});
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h00, 8'h00);
    chk("hit", 16'h0, {15'h0, hit});
    wr(8'ha9, 8'hff);
    rd(8'ha9, 8'h3f);
    chk("hit", 16'h1, {15'h0, hit});
    wr(8'ha9, 8'h00);
    wr(8'ha8, 8'hbf);
    wr(8'hb8, 8'h3f);
    wr(8'h9a, 8'h03);
    rd(8'hb8, 8'h3f);
    for (int i = 0; i < 13; i++) begin
      @(negedge mclk) per = pm[i];
      if (i < 11) @(negedge mclk) per = '0;
      vw(va[i], 2'h0);
      per = '0;
      rd(8'hc0, fb[i]);
      rd(8'he1, 8'h00);
      wr(8'hc0, 8'h00);
      ret(4'h0);
    end
    lng = 1'b1;
    for (int l = 0; l < 4; l++) begin
      lv = l[1:0];
      wr(8'ha9, {7'h0, lv[0]});
      wr(8'hb9, {7'h0, lv[1]});
      @(negedge mclk) per = pm[4];
      @(negedge mclk) per = '0;
      vw(16'h0043, lv);
      wr(8'hc0, 8'h00);
      ret(4'h0);
    end
    lng = 1'b0;
    wr(8'ha9, 8'h20);
    wr(8'hb9, 8'h20);
    @(negedge mclk) per = 13'h1400;
    @(negedge mclk) per = '0;
    vw(16'h002b, 2'h3);
    nv(60);
    wr(8'hc0, 8'h00);
    ret(4'h0);
    vw(16'h000b, 2'h0);
    ret(4'h0);
    // level 3 request while a level 0 routine runs
    @(negedge mclk) per = pm[0];
    @(negedge mclk) per = '0;
    vw(16'h000b, 2'h0);
    @(negedge mclk) per = pm[2];
    @(negedge mclk) per = '0;
    vw(16'h002b, 2'h3);
    wr(8'hc0, 8'h00);
    ret(4'h1);
    ret(4'h0);
    wr(8'ha9, 8'h00);
    wr(8'hb9, 8'h00);
    @(negedge mclk) per = 13'h1100;
    @(negedge mclk) per = '0;
    vw(16'h0043, 2'h0);
    wr(8'hc0, 8'h00);
    ret(4'h0);
    vw(16'h000b, 2'h0);
    ret(4'h0);
    wr(8'ha8, 8'h3f);
    @(negedge mclk) per = pm[0];
    @(negedge mclk) per = '0;
    nv(40);
    wr(8'h88, 8'h00);
    wr(8'ha8, 8'hbf);
    nv(60);
    wr(8'h88, 8'h20);
    vw(16'h000b, 2'h0);
    ret(4'h0);
    wr(8'h88, 8'h02);
    rd(8'h88, 8'h00);
    @(negedge mclk) pin_n = 2'h2;
    vw(16'h0003, 2'h0);
    rd(8'h88, 8'h02);
    pin_n = 2'h3;
    nv(30);
    ret(4'h0);
    @(negedge mclk) latch = 2'h2;
    vw(16'h0003, 2'h0);
    latch = 2'h3;
    nv(30);
    ret(4'h0);
    wr(8'h88, 8'h01);
    @(negedge mclk) pin_n = 2'h2;
    vw(16'h0003, 2'h0);
    rd(8'h88, 8'h01);
    pin_n = 2'h3;
    ret(4'h0);
    // external 1 in edge mode
    wr(8'h88, 8'h04);
    @(negedge mclk) pin_n = 2'h1;
    vw(16'h0013, 2'h0);
    rd(8'h88, 8'h04);
    pin_n = 2'h3;
    ret(4'h0);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== hdl/flic_controller.sv ====
// four-level interrupt controller: flags, enables, priorities, polling, vectoring
`default_nettype none
module flic_controller (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // register access
  input wire flic_pkg::flic_sfr_req_type SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  // external interrupt 0 and 1 pins and port latch bits
  input wire logic [1:0] EXT01_PIN_N,
  input wire logic [1:0] EXT01_LATCH,
  // peripheral request events
  input wire flic_pkg::flic_periph_type PERIPH,
  // cpu sequencer
  input wire flic_pkg::flic_cpu_type CPU,
  output var flic_pkg::flic_vec_type VEC,
  output logic SAMPLE_POINT,
  output logic CYCLE_END,
  output logic [3:0] LEVEL_ACTIVE
);

  flic_pkg::flic_state_type st_ff;
  flic_pkg::flic_state_type nxt_st;
  logic sample_stb;
  logic cycle_end;
  logic [1:0] eff_lvl;
  logic [flic_pkg::NUM_SRC-1:0] flags;
  logic [flic_pkg::NUM_SRC-1:0] en_vec;
  logic wr_ctl;
  logic go;

  // ****************************************************************
  // machine cycle strobes
  // ****************************************************************
  flic_cycle_gen #(
    .PHASES(flic_pkg::PHASES_PER_CYCLE)
  ) u_cycle (
    .clk(MCLK),
    .reset_n(RESET_N),
    .sample_stb(sample_stb),
    .cycle_end(cycle_end)
  );

  // ****************************************************************
  // request and enable vectors in polling order
  // ****************************************************************
  assign eff_lvl = EXT01_PIN_N & EXT01_LATCH;
  assign flags = {st_ff.flags_b[flic_pkg::FB_EXT2+4],
                  st_ff.flags_b[flic_pkg::FB_TF2] | st_ff.flags_b[flic_pkg::FB_TIMER2_RELOAD_REQUEST],
                  st_ff.flags_b[flic_pkg::FB_EXT2+3], PERIPH.serial0_flag,
                  st_ff.flags_b[flic_pkg::FB_EXT2+2], st_ff.compare_timer_rollover_flag, st_ff.tf1,
                  st_ff.flags_b[flic_pkg::FB_EXT2+1], st_ff.ext_req[1],
                  st_ff.flags_b[flic_pkg::FB_EXT2], st_ff.tf0,
                  st_ff.flags_b[flic_pkg::FB_ADC], PERIPH.serial1_flag, st_ff.ext_req[0]};
  assign en_vec = {st_ff.en_b[5], st_ff.en_a[5], st_ff.en_b[4], st_ff.en_a[4],
                   st_ff.en_b[3], st_ff.en_c[1], st_ff.en_a[3], st_ff.en_b[2],
                   st_ff.en_a[2], st_ff.en_b[1], st_ff.en_a[1], st_ff.en_b[0],
                   st_ff.en_c[0], st_ff.en_a[0]};
  assign wr_ctl = SFR_REQ.wr && (SFR_REQ.addr == flic_pkg::ADDR_EN_A ||
                  SFR_REQ.addr == flic_pkg::ADDR_EN_B || SFR_REQ.addr == flic_pkg::ADDR_EN_C ||
                  SFR_REQ.addr == flic_pkg::ADDR_PRIO_LO ||
                  SFR_REQ.addr == flic_pkg::ADDR_PRIO_HI);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [flic_pkg::NUM_SRC-1:0] cand;
    logic found;
    logic any_act;
    logic hold_now;
    logic [1:0] best_lvl;
    logic [1:0] lvl;
    logic [1:0] cur_lvl;
    logic [3:0] best_src;
    logic [2:0] grp;
    logic [7:0] fb_clr;
    logic [7:0] fb_set;
    logic wr_a;
    cand = '0;
    found = 1'b0;
    any_act = 1'b0;
    hold_now = 1'b0;
    best_lvl = '0;
    lvl = '0;
    cur_lvl = '0;
    best_src = '0;
    grp = '0;
    fb_clr = '0;
    fb_set = '0;
    wr_a = SFR_REQ.wr && SFR_REQ.addr == flic_pkg::ADDR_FLAGS_A;
    nxt_st = st_ff;
    // arbitration over the flags polled this cycle
    cand = st_ff.polled & en_vec & {flic_pkg::NUM_SRC{st_ff.en_a[flic_pkg::EN_A_GLOBAL]}};
    for (int i = 0; i < flic_pkg::NUM_SRC; i++) begin
      grp = flic_pkg::flic_group(4'(i));
      lvl = {st_ff.prio_hi[grp], st_ff.prio_lo[grp]};
      if (cand[i] && (!found || lvl > best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl;
        best_src = 4'(i);
      end
    end
    for (int j = 0; j < flic_pkg::NUM_LVL; j++) begin
      if (st_ff.active[j]) begin
        cur_lvl = 2'(j);
      end
    end
    any_act = |st_ff.active;
    hold_now = st_ff.hold | wr_ctl | CPU.interrupt_return;
    // polled values only; nothing is kept for a later poll
    go = cycle_end && CPU.final_cycle && found && !hold_now &&
         (!any_act || best_lvl > cur_lvl);
    // sampling and polling pipeline
    if (sample_stb) begin
      nxt_st.sampled = flags;
      nxt_st.pin_prev = eff_lvl;
    end
    if (cycle_end) begin
      nxt_st.polled = st_ff.sampled;
    end
    // external 0 and 1: vector clear, write, then pin (set wins)
    for (int k = 0; k < 2; k++) begin
      if (go && best_src == (k == 0 ? flic_pkg::SRC_EXT0 : flic_pkg::SRC_EXT1) &&
          st_ff.trig_type[k]) begin
        nxt_st.ext_req[k] = 1'b0;
      end
      if (wr_a) begin
        if (!SFR_REQ.wdata[k == 0 ? flic_pkg::FA_IE0 : flic_pkg::FA_IE1]) begin
          nxt_st.ext_req[k] = 1'b0;
        end else if (st_ff.trig_type[k]) begin
          nxt_st.ext_req[k] = 1'b1;
        end
        nxt_st.trig_type[k] = SFR_REQ.wdata[k == 0 ? flic_pkg::FA_IT0 : flic_pkg::FA_IT1];
      end
      if (sample_stb) begin
        if (!st_ff.trig_type[k]) begin
          nxt_st.ext_req[k] = !eff_lvl[k];
        end else if (st_ff.pin_prev[k] && !eff_lvl[k]) begin
          nxt_st.ext_req[k] = 1'b1;
        end
      end
    end
    // timer 0 and 1 flags
    if (go && best_src == flic_pkg::SRC_TMR0) begin
      nxt_st.tf0 = 1'b0;
    end
    if (go && best_src == flic_pkg::SRC_TMR1) begin
      nxt_st.tf1 = 1'b0;
    end
    if (wr_a) begin
      nxt_st.tf0 = SFR_REQ.wdata[flic_pkg::FA_TF0];
      nxt_st.tf1 = SFR_REQ.wdata[flic_pkg::FA_TF1];
    end
    nxt_st.tf0 = nxt_st.tf0 | PERIPH.timer0_overflow_request;
    nxt_st.tf1 = nxt_st.tf1 | PERIPH.timer1_overflow_request;
    // second flag byte: ext2..6 cleared on vector, adc and timer 2 left alone
    for (int e = 0; e < 5; e++) begin
      if (go && best_src == (e == 0 ? flic_pkg::SRC_EXT2 : e == 1 ? flic_pkg::SRC_EXT3 :
          e == 2 ? flic_pkg::SRC_EXT4 : e == 3 ? flic_pkg::SRC_EXT5 : flic_pkg::SRC_EXT6)) begin
        fb_clr[flic_pkg::FB_EXT2+e] = 1'b1;
      end
    end
    fb_set = {PERIPH.timer2_reload_request, PERIPH.timer2_overflow_request,
              PERIPH.ext_edge_request, PERIPH.adc_done_request};
    nxt_st.flags_b = st_ff.flags_b & ~fb_clr;
    if (SFR_REQ.wr && SFR_REQ.addr == flic_pkg::ADDR_FLAGS_B) begin
      nxt_st.flags_b = SFR_REQ.wdata;
    end
    nxt_st.flags_b = nxt_st.flags_b | fb_set;
    // compare timer flag
    if (go && best_src == flic_pkg::SRC_CT) begin
      nxt_st.compare_timer_rollover_flag = 1'b0;
    end
    if (SFR_REQ.wr && SFR_REQ.addr == flic_pkg::ADDR_CT_CTRL) begin
      nxt_st.compare_timer_rollover_flag = SFR_REQ.wdata[flic_pkg::CT_CTF];
    end
    nxt_st.compare_timer_rollover_flag = nxt_st.compare_timer_rollover_flag | PERIPH.compare_timer_rollover;
    // enable and priority registers
    if (SFR_REQ.wr) begin
      case (SFR_REQ.addr)
        flic_pkg::ADDR_EN_A: nxt_st.en_a = SFR_REQ.wdata;
        flic_pkg::ADDR_EN_B: nxt_st.en_b = SFR_REQ.wdata[5:0];
        flic_pkg::ADDR_EN_C: nxt_st.en_c = SFR_REQ.wdata[1:0];
        flic_pkg::ADDR_PRIO_LO: nxt_st.prio_lo = SFR_REQ.wdata[5:0];
        flic_pkg::ADDR_PRIO_HI: nxt_st.prio_hi = SFR_REQ.wdata[5:0];
        default: nxt_st.hit = st_ff.hit;
      endcase
    end
    // blocking after a return or a control write lasts to the next final cycle
    if (cycle_end && CPU.final_cycle) begin
      nxt_st.hold = 1'b0;
    end
    if (wr_ctl || CPU.interrupt_return) begin
      nxt_st.hold = 1'b1;
    end
    // in-progress levels; a plain return is never seen here
    if (CPU.interrupt_return && any_act) begin
      nxt_st.active[cur_lvl] = 1'b0;
    end
    nxt_st.vec.call = go;
    if (go) begin
      nxt_st.active[best_lvl] = 1'b1;
      nxt_st.vec.addr = flic_pkg::flic_vector(best_src);
      nxt_st.vec.level = best_lvl;
      nxt_st.vec.src = best_src;
    end
    // read data
    nxt_st.hit = 1'b1;
    case (SFR_REQ.addr)
      flic_pkg::ADDR_FLAGS_A: nxt_st.rdata = {st_ff.tf1, 1'b0, st_ff.tf0, 1'b0, st_ff.ext_req[1],
                                              st_ff.trig_type[1], st_ff.ext_req[0],
                                              st_ff.trig_type[0]};
      flic_pkg::ADDR_FLAGS_B: nxt_st.rdata = st_ff.flags_b;
      flic_pkg::ADDR_EN_A: nxt_st.rdata = st_ff.en_a;
      flic_pkg::ADDR_EN_B: nxt_st.rdata = {2'h0, st_ff.en_b};
      flic_pkg::ADDR_EN_C: nxt_st.rdata = {6'h00, st_ff.en_c};
      flic_pkg::ADDR_PRIO_LO: nxt_st.rdata = {2'h0, st_ff.prio_lo};
      flic_pkg::ADDR_PRIO_HI: nxt_st.rdata = {2'h0, st_ff.prio_hi};
      flic_pkg::ADDR_CT_CTRL: nxt_st.rdata = 8'(st_ff.compare_timer_rollover_flag) << flic_pkg::CT_CTF;
      default: begin
        nxt_st.rdata = flic_pkg::RST_BYTE;
        nxt_st.hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '0;
      st_ff.pin_prev <= flic_pkg::RST_PIN_PREV;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign VEC = st_ff.vec;
  assign SFR_RDATA = st_ff.rdata;
  assign SFR_HIT = st_ff.hit;
  assign SAMPLE_POINT = sample_stb;
  assign CYCLE_END = cycle_end;
  assign LEVEL_ACTIVE = st_ff.active;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  AST_CALL_ON_FINAL: assert property (VEC.call |-> $past(CPU.final_cycle) && $past(cycle_end))
    else $error("call issued outside a final cycle end");
  AST_CALL_ENABLED: assert property (VEC.call |-> $past(st_ff.en_a[flic_pkg::EN_A_GLOBAL]) &&
      ($past(en_vec & st_ff.polled) & (flic_pkg::NUM_SRC'(1) << VEC.src)) != '0)
    else $error("call for a source that was not enabled and polled");
  AST_STRICT_PREEMPT: assert property (VEC.call && $past(st_ff.active) != '0 |->
      $past(st_ff.active) < (4'h1 << VEC.level))
    else $error("pre-emption without a strictly higher level");
  AST_RETURN_BLOCKS: assert property (CPU.interrupt_return |=> !VEC.call)
    else $error("call right after a return");
  AST_RETURN_DROPS: assert property (CPU.interrupt_return && st_ff.active != '0 |=>
      $countones(st_ff.active) == $countones($past(st_ff.active)) - 1)
    else $error("return did not drop a level");
  AST_CT_CLEARED: assert property (VEC.call && VEC.src == flic_pkg::SRC_CT &&
      !$past(PERIPH.compare_timer_rollover) |-> !st_ff.compare_timer_rollover_flag)
    else $error("compare timer flag not cleared on call");
  AST_LEVEL_FOLLOW: assert property (sample_stb && !st_ff.trig_type[0] |=>
      st_ff.ext_req[0] == !$past(eff_lvl[0]))
    else $error("level mode flag does not follow pin");
  AST_EDGE_SET: assert property (sample_stb && st_ff.trig_type[0] && st_ff.pin_prev[0] &&
      !eff_lvl[0] |=> st_ff.ext_req[0])
    else $error("falling edge did not set flag");
  AST_POLL_PIPE: assert property (cycle_end |=> st_ff.polled == $past(st_ff.sampled))
    else $error("poll did not take the last sample");
  AST_SET_WINS: assert property (PERIPH.timer2_overflow_request |=>
      st_ff.flags_b[flic_pkg::FB_TF2])
    else $error("timer 2 event lost");

  COV_CALL: cover property (VEC.call);
  COV_PREEMPT: cover property (VEC.call && $past(st_ff.active) != '0);
  COV_RETURN: cover property (CPU.interrupt_return && st_ff.active != '0);

endmodule
`default_nettype wire

// ==== hdl/flic_cycle_gen.sv ====
// machine cycle divider giving the sample-point and cycle-end strobes
`default_nettype none
module flic_cycle_gen #(
  parameter int PHASES = flic_pkg::PHASES_PER_CYCLE
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // strobes
  output logic sample_stb,
  output logic cycle_end
);

  flic_pkg::flic_div_state_type st_ff;
  flic_pkg::flic_div_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (cycle_end) begin
      nxt_st.phase = '0;
    end else begin
      nxt_st.phase = st_ff.phase + flic_pkg::PHASE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sample_stb = (st_ff.phase == flic_pkg::PHASE_W'(flic_pkg::SAMPLE_PHASE));
  assign cycle_end = (st_ff.phase == flic_pkg::PHASE_W'(PHASES - 1));

endmodule
`default_nettype wire

// ==== hdl/flic_pkg.sv ====
// constants, tables and carrier types of the four-level interrupt controller
`default_nettype none
package flic_pkg;

  // ****************************************************************
  // machine cycle timing, counted in clock periods
  // ****************************************************************
  localparam int PHASES_PER_CYCLE = 12;
  localparam int SAMPLE_PHASE = 9;
  localparam int LAST_PHASE = 11;
  localparam int PHASE_W = 4;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_FLAGS_A = 8'h88;
  localparam logic [7:0] ADDR_EN_C = 8'h9a;
  localparam logic [7:0] ADDR_EN_A = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LO = 8'ha9;
  localparam logic [7:0] ADDR_EN_B = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_HI = 8'hb9;
  localparam logic [7:0] ADDR_FLAGS_B = 8'hc0;
  localparam logic [7:0] ADDR_CT_CTRL = 8'he1;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int FA_IT0 = 0;
  localparam int FA_IE0 = 1;
  localparam int FA_IT1 = 2;
  localparam int FA_IE1 = 3;
  localparam int FA_TF0 = 5;
  localparam int FA_TF1 = 7;
  localparam int FB_ADC = 0;
  localparam int FB_EXT2 = 1;
  localparam int FB_TF2 = 6;
  localparam int FB_TIMER2_RELOAD_REQUEST = 7;
  localparam int CT_CTF = 3;
  localparam int EN_A_GLOBAL = 7;
  localparam int NUM_SRC = 14;
  localparam int NUM_GRP = 6;
  localparam int NUM_LVL = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PIN_PREV = 2'h3;

  // ****************************************************************
  // sources, numbered in same-level polling order
  // ****************************************************************
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_SER1 = 4'h1;
  localparam logic [3:0] SRC_ADC = 4'h2;
  localparam logic [3:0] SRC_TMR0 = 4'h3;
  localparam logic [3:0] SRC_EXT2 = 4'h4;
  localparam logic [3:0] SRC_EXT1 = 4'h5;
  localparam logic [3:0] SRC_EXT3 = 4'h6;
  localparam logic [3:0] SRC_TMR1 = 4'h7;
  localparam logic [3:0] SRC_CT = 4'h8;
  localparam logic [3:0] SRC_EXT4 = 4'h9;
  localparam logic [3:0] SRC_SER0 = 4'ha;
  localparam logic [3:0] SRC_EXT5 = 4'hb;
  localparam logic [3:0] SRC_TMR2 = 4'hc;
  localparam logic [3:0] SRC_EXT6 = 4'hd;

  // priority group of a source
  function automatic logic [2:0] flic_group(input logic [3:0] src);
    case (src)
      SRC_EXT0, SRC_SER1, SRC_ADC: flic_group = 3'h0;
      SRC_TMR0, SRC_EXT2: flic_group = 3'h1;
      SRC_EXT1, SRC_EXT3: flic_group = 3'h2;
      SRC_TMR1, SRC_CT, SRC_EXT4: flic_group = 3'h3;
      SRC_SER0, SRC_EXT5: flic_group = 3'h4;
      default: flic_group = 3'h5;
    endcase
  endfunction

  // service routine entry address of a source
  function automatic logic [15:0] flic_vector(input logic [3:0] src);
    case (src)
      SRC_EXT0: flic_vector = 16'h0003;
      SRC_TMR0: flic_vector = 16'h000b;
      SRC_EXT1: flic_vector = 16'h0013;
      SRC_TMR1: flic_vector = 16'h001b;
      SRC_SER0: flic_vector = 16'h0023;
      SRC_TMR2: flic_vector = 16'h002b;
      SRC_ADC: flic_vector = 16'h0043;
      SRC_EXT2: flic_vector = 16'h004b;
      SRC_EXT3: flic_vector = 16'h0053;
      SRC_EXT4: flic_vector = 16'h005b;
      SRC_EXT5: flic_vector = 16'h0063;
      SRC_EXT6: flic_vector = 16'h006b;
      SRC_SER1: flic_vector = 16'h0083;
      default: flic_vector = 16'h009b;
    endcase
  endfunction

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } flic_sfr_req_type;

  typedef struct packed {
    logic timer0_overflow_request;
    logic timer1_overflow_request;
    logic timer2_overflow_request;
    logic timer2_reload_request;
    logic adc_done_request;
    logic [4:0] ext_edge_request;
    logic compare_timer_rollover;
    logic serial0_flag;
    logic serial1_flag;
  } flic_periph_type;

  typedef struct packed {
    logic final_cycle;
    logic interrupt_return;
  } flic_cpu_type;

  typedef struct packed {
    logic call;
    logic [15:0] addr;
    logic [1:0] level;
    logic [3:0] src;
  } flic_vec_type;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
  } flic_div_state_type;

  typedef struct packed {
    logic [7:0] en_a;
    logic [5:0] en_b;
    logic [1:0] en_c;
    logic [5:0] prio_lo;
    logic [5:0] prio_hi;
    logic [1:0] trig_type;
    logic [1:0] ext_req;
    logic [1:0] pin_prev;
    logic tf0;
    logic tf1;
    logic [7:0] flags_b;
    logic compare_timer_rollover_flag;
    logic [NUM_SRC-1:0] sampled;
    logic [NUM_SRC-1:0] polled;
    logic [NUM_LVL-1:0] active;
    logic hold;
    flic_vec_type vec;
    logic [7:0] rdata;
    logic hit;
  } flic_state_type;

endpackage
`default_nettype wire
